//--- phy_diag_pkg.sv
// phy_diag_pkg: register addresses, field positions and reset values of the
// diagnostic and transceiver gain control registers.
// assumes a 5-bit management register address and 16-bit register data.
package phyd_pkg;
  // management register addresses
  localparam logic [4:0]  ADDR_DIAG      = 5'h12;
  localparam logic [4:0]  ADDR_GAIN      = 5'h13;
  // reset values and the value read from unmapped addresses
  localparam logic [15:0] DIAG_RESET     = 16'h0000;
  localparam logic [15:0] GAIN_RESET     = 16'h4000;
  localparam logic [15:0] UNMAPPED_VALUE = 16'h0000;
  // diagnostic field positions
  localparam int          BIT_NEG_FAIL   = 12;
  localparam int          BIT_FULL_NEGOTIATED_FULL_DUPLEX  = 11;
  localparam int          BIT_RATE_100   = 10;
  localparam int          BIT_RX_SIGNAL  = 9;
  localparam int          BIT_RX_LOCK    = 8;
endpackage : phyd_pkg

//--- phyd_sync.sv
// phyd_sync: two-flop synchroniser for a vector of level inputs.
// assumes inputs are levels from outside the clk domain.
`timescale 1ns/10ps
module phyd_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;       // first flop, read only by syncOut
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_syncOut;

  // a vector of no bits cannot be synchronised; refuse it at elaboration
  if (WIDTH < 1) begin : g_width_check
    $error("phyd_sync WIDTH must be at least 1");
  end

  // next values of both stages
  always_comb begin
    next_stage1  = asyncIn;
    next_syncOut = stage1;
  end

  // register the stages; reset to a known low
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end
endmodule : phyd_sync

//--- phyd_regs.sv
// phyd_regs: diagnostic register and transceiver gain control register of
// the transceiver management register space.
// assumes a one-cycle read strobe and write strobe from the management
// path on clk; status inputs come from other clock domains of the analog
// front end and are synchronised here.
// How it works
// - diagnostic register at 0x12, read-only, resets zero
// - bit 12 failure flag sticks, cleared by read
// - bit 11 shows negotiated full versus half duplex
// - bit 10 shows negotiated 100 versus 10 rate
// - bit 9 shows receive signal or Manchester data
// - bit 8 shows receive PLL lock
// - reserved bits read zero; software preserves them
// - gain control register at 0x13, resets 0x4000
`timescale 1ns/10ps
module phyd_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // management register access
  input  wire logic [4:0]  regAddr,
  input  wire logic        regRead,
  input  wire logic        regWrite,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  // negotiation engine, asynchronous levels
  input  wire logic        negDone,
  input  wire logic        negNoCommon,
  input  wire logic        negFullDuplex,
  input  wire logic        negRate100,
  // receiver status, asynchronous levels
  input  wire logic        rxSignalSeen,
  input  wire logic        rxPllLocked,
  // gain control output
  output logic      [15:0] gainControl
);
  // positions of the status levels inside the synchroniser vector
  localparam int SYNC_WIDTH     = 6;
  localparam int SYNC_DONE      = 5;
  localparam int SYNC_NO_COMMON = 4;
  localparam int SYNC_FULL_NEGOTIATED_FULL_DUPLEX = 3;
  localparam int SYNC_RATE_100  = 2;
  localparam int SYNC_RX_SIGNAL = 1;
  localparam int SYNC_RX_LOCK   = 0;

  logic [SYNC_WIDTH-1:0] syncIn;        // synchronised status levels
  logic        doneSync;                // negotiation done, synchronised
  logic        doneSeen;                // done level one cycle ago
  logic        doneRise;                // completion event
  logic        negotiationFailedFlag;   // sticky failure flag
  logic        negotiatedFullDuplex;    // latched duplex result
  logic        negotiatedRate100;       // latched rate result
  logic [15:0] diagValue;               // assembled diagnostic word
  logic        next_doneSeen;
  logic        next_failFlag;
  logic        next_fullDuplex;
  logic        next_rate100;
  logic [15:0] next_gain;
  logic [15:0] next_rdata;

  // status pins cross from the front end before anything reads them
  phyd_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({negDone, negNoCommon, negFullDuplex, negRate100,
               rxSignalSeen, rxPllLocked}),
    .syncOut (syncIn)
  );

  assign doneSync = syncIn[SYNC_DONE];
  // edge taken on synchronised level, so a long done pulse counts once
  assign doneRise = doneSync & ~doneSeen;

  // assemble the diagnostic word; all unnamed bits stay zero
  always_comb begin
    diagValue                            = phyd_pkg::DIAG_RESET;
    diagValue[phyd_pkg::BIT_NEG_FAIL]    = negotiationFailedFlag;
    diagValue[phyd_pkg::BIT_FULL_NEGOTIATED_FULL_DUPLEX]   = negotiatedFullDuplex;
    diagValue[phyd_pkg::BIT_RATE_100]    = negotiatedRate100;
    diagValue[phyd_pkg::BIT_RX_SIGNAL]   = syncIn[SYNC_RX_SIGNAL];
    diagValue[phyd_pkg::BIT_RX_LOCK]     = syncIn[SYNC_RX_LOCK];
  end

  // next state of the status flags and the gain register
  always_comb begin
    next_doneSeen   = doneSync;
    next_fullDuplex = negotiatedFullDuplex;
    next_rate100    = negotiatedRate100;
    next_failFlag   = negotiationFailedFlag;
    next_gain       = gainControl;
    next_rdata      = regRdata;
    // a read of the diagnostic register clears the failure flag
    if (regRead && regAddr == phyd_pkg::ADDR_DIAG) begin
      next_failFlag = 1'b0;
    end
    // a new failure in the read cycle wins over the clear
    if (doneRise && syncIn[SYNC_NO_COMMON]) begin
      next_failFlag = 1'b1;
    end
    // results move only when a negotiation finishes
    if (doneRise) begin
      next_fullDuplex = syncIn[SYNC_FULL_NEGOTIATED_FULL_DUPLEX];
      next_rate100    = syncIn[SYNC_RATE_100];
    end
    // gain register is the only writable one; writes elsewhere are dropped
    if (regWrite && regAddr == phyd_pkg::ADDR_GAIN) begin
      next_gain = regWdata;
    end
    // read data captured on the strobe and held until the next read
    if (regRead) begin
      case (regAddr)
        phyd_pkg::ADDR_DIAG: next_rdata = diagValue;
        phyd_pkg::ADDR_GAIN: next_rdata = gainControl;
        default:             next_rdata = phyd_pkg::UNMAPPED_VALUE;
      endcase
    end
  end

  // register everything; reset gives the documented values
  always_ff @(posedge clk) begin
    if (rst) begin
      doneSeen              <= 1'b0;
      negotiationFailedFlag <= 1'b0;
      negotiatedFullDuplex  <= 1'b0;
      negotiatedRate100     <= 1'b0;
      gainControl           <= phyd_pkg::GAIN_RESET;
      regRdata              <= '0;
    end else begin
      doneSeen              <= next_doneSeen;
      negotiationFailedFlag <= next_failFlag;
      negotiatedFullDuplex  <= next_fullDuplex;
      negotiatedRate100     <= next_rate100;
      gainControl           <= next_gain;
      regRdata              <= next_rdata;
    end
  end

  // failure event sets the flag on the next edge
  property p_fail_set;
    @(posedge clk) disable iff (rst)
      (doneRise && syncIn[4]) |=> negotiationFailedFlag;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("failure flag not set");

  // a read with no new failure clears the flag
  property p_fail_clear;
    @(posedge clk) disable iff (rst)
      (regRead && regAddr == phyd_pkg::ADDR_DIAG && !(doneRise && syncIn[4]))
        |=> !negotiationFailedFlag;
  endproperty
  a_fail_clear: assert property (p_fail_clear) else $error("failure flag not cleared");

  // the flag never sets without a failure event
  property p_fail_cause;
    @(posedge clk) disable iff (rst)
      $rose(negotiationFailedFlag) |-> $past(doneRise && syncIn[4]);
  endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("failure flag set by itself");

  // duplex and rate hold between negotiations
  property p_result_hold;
    @(posedge clk) disable iff (rst)
      !doneRise |=> $stable({negotiatedFullDuplex, negotiatedRate100});
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved");

  // a completed negotiation loads duplex and rate
  property p_result_load;
    @(posedge clk) disable iff (rst)
      doneRise |=> (negotiatedFullDuplex == $past(syncIn[3]))
                && (negotiatedRate100 == $past(syncIn[2]));
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded");

  // diagnostic read returns zero in reserved bits
  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      (regRead && regAddr == phyd_pkg::ADDR_DIAG)
        |=> (regRdata[15:13] == 3'h0) && (regRdata[7:0] == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  // diagnostic read shows receive status from the cycle of the strobe
  property p_rx_status;
    @(posedge clk) disable iff (rst)
      (regRead && regAddr == phyd_pkg::ADDR_DIAG)
        |=> (regRdata[9:8] == $past(syncIn[1:0]));
  endproperty
  a_rx_status: assert property (p_rx_status) else $error("receive status wrong");

  // gain write lands, and nothing else moves the gain
  property p_gain_write;
    @(posedge clk) disable iff (rst)
      (regWrite && regAddr == phyd_pkg::ADDR_GAIN) |=> gainControl == $past(regWdata);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain write lost");

  property p_gain_hold;
    @(posedge clk) disable iff (rst)
      !(regWrite && regAddr == phyd_pkg::ADDR_GAIN) |=> $stable(gainControl);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain moved");

  // diagnostic register cannot be written
  property p_diag_ro;
    @(posedge clk) disable iff (rst)
      (regWrite && !regRead && regAddr == phyd_pkg::ADDR_DIAG && !doneRise)
        |=> $stable({negotiationFailedFlag, negotiatedFullDuplex, negotiatedRate100});
  endproperty
  a_diag_ro: assert property (p_diag_ro) else $error("diagnostic register written");

  // a diagnostic read shows the latched flags as they stood at the strobe,
  // so a failure landing on the read edge is seen by the next read only
  property p_read_flags;
    @(posedge clk) disable iff (rst)
      (regRead && regAddr == phyd_pkg::ADDR_DIAG)
        |=> (regRdata[12:10] == $past({negotiationFailedFlag, negotiatedFullDuplex,
                                       negotiatedRate100}));
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("diagnostic flags misread");

  // a gain read returns the register contents at the strobe
  property p_gain_read;
    @(posedge clk) disable iff (rst)
      (regRead && regAddr == phyd_pkg::ADDR_GAIN) |=> regRdata == $past(gainControl);
  endproperty
  a_gain_read: assert property (p_gain_read) else $error("gain read wrong");

  // reads outside the two registers return zero
  property p_unmapped_zero;
    @(posedge clk) disable iff (rst)
      (regRead && regAddr != phyd_pkg::ADDR_DIAG && regAddr != phyd_pkg::ADDR_GAIN)
        |=> regRdata == phyd_pkg::UNMAPPED_VALUE;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  // read data stands until the next read strobe
  property p_rdata_hold;
    @(posedge clk) disable iff (rst)
      !regRead |=> $stable(regRdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule : phyd_regs

//--- phyd_host_model.sv
// phyd_host_model: management host that polls and writes phy registers.
// assumes the bench calls its tasks; strobes change on falling clk edges.
`timescale 1ns/10ps
module phyd_host_model (
  // clock
  input  wire logic        clk,
  // management register access
  output logic      [4:0]  regAddr,
  output logic             regRead,
  output logic             regWrite,
  output logic      [15:0] regWdata,
  input  wire logic [15:0] regRdata
);
  // idle bus at time zero
  initial begin
    regAddr  = 5'h00;
    regRead  = 1'b0;
    regWrite = 1'b0;
    regWdata = 16'h0000;
  end

  // one-cycle read strobe; data taken once the answering edge has passed
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    regAddr = ~a; // stale address must not look valid
    d       = regRdata;
  endtask : rd

  // one-cycle write strobe; data inverted after release
  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    @(negedge clk);
    regAddr  = a;
    regWdata = w;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regAddr  = ~a;
    regWdata = ~w;
  endtask : wr

  // read-modify-write keeps every bit outside the mask as read
  task automatic rmw(input logic [4:0] a, input logic [15:0] m, input logic [15:0] v);
    logic [15:0] d;
    rd(a, d);
    wr(a, (d & ~m) | (v & m));
  endtask : rmw
endmodule : phyd_host_model

//--- phy_autoneg_diagnostic_regs_test.sv
// phy_autoneg_diagnostic_regs_test: self-checking bench for phyd_regs.
// assumes phyd_pkg and the host model are compiled first.
`timescale 1ns/10ps
module phy_autoneg_diagnostic_regs_test;
  logic        clk = 1'b0;    // 50 MHz clock, low before any process starts
  logic        rst;           // synchronous reset
  logic [4:0]  regAddr;       // host address
  logic        regRead;       // host read strobe
  logic        regWrite;      // host write strobe
  logic [15:0] regWdata;      // host write data
  logic [15:0] regRdata;      // read answer
  logic        negDone;       // negotiation finished
  logic        negNoCommon;   // no common technology
  logic        negFullDuplex; // full duplex result
  logic        negRate100;    // 100 Mb/s result
  logic        rxSignalSeen;  // receive signal seen
  logic        rxPllLocked;   // receive pll locked
  logic [15:0] gainControl;   // gain register contents
  logic [15:0] d;             // last read word
  int          errors;
  int          num_checks;
  int          cycles;

  phyd_regs u_phyd_regs (.clk(clk), .rst(rst), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .negDone(negDone),
    .negNoCommon(negNoCommon), .negFullDuplex(negFullDuplex), .negRate100(negRate100),
    .rxSignalSeen(rxSignalSeen), .rxPllLocked(rxPllLocked), .gainControl(gainControl));
  phyd_host_model u_phyd_host_model (.clk(clk), .regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata));

  // clock generator
  always #10 clk = ~clk;

  // hang guard: the whole sequence needs well under 300 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one negotiation: levels settle with the rising completion, held 5 cycles
  task automatic neg(input logic nc, input logic fd, input logic r);
    @(negedge clk);
    negNoCommon   = nc;
    negFullDuplex = fd;
    negRate100    = r;
    negDone       = 1'b1;
    repeat (5) @(negedge clk);
    negDone = 1'b0;
    repeat (3) @(negedge clk);
  endtask : neg

  task automatic wrap_up();
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    {negDone, negNoCommon, negFullDuplex, negRate100, rxSignalSeen, rxPllLocked} = 6'h00;
    errors = 0;
    num_checks = 0;
    cycles = 0;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, phyd_pkg::DIAG_RESET);
    u_phyd_host_model.rd(phyd_pkg::ADDR_GAIN, d);
    check(d, 16'h4000);
    check(gainControl, 16'h4000);
    u_phyd_host_model.rd(5'h05, d);
    check(d, 16'h0000);
    u_phyd_host_model.wr(phyd_pkg::ADDR_GAIN, 16'h1234);
    check(gainControl, 16'h1234);
    u_phyd_host_model.rd(phyd_pkg::ADDR_GAIN, d);
    check(d, 16'h1234);
    neg(1'b1, 1'b1, 1'b1);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h1c00);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h0c00);
    neg(1'b0, 1'b0, 1'b0);
    negFullDuplex = 1'b1;
    negRate100 = 1'b1;
    repeat (4) @(negedge clk);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h0000);
    neg(1'b0, 1'b1, 1'b0);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h0800);
    neg(1'b0, 1'b0, 1'b1);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h0400);
    rxSignalSeen = 1'b1;
    repeat (3) @(negedge clk);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h0600);
    rxPllLocked = 1'b1;
    repeat (3) @(negedge clk);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h0700);
    u_phyd_host_model.rmw(phyd_pkg::ADDR_DIAG, 16'hffff, 16'hffff);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h0700);
    check(gainControl, 16'h1234);
    // failure lands on the edge of a diagnostic read: the read shows the old
    // word, the set wins over the clear, and the next read shows the flag
    {negNoCommon, negFullDuplex, negDone} = 3'b111;
    @(negedge clk);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h0700);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h1f00);
    negDone = 1'b0;
    // reset in mid-run returns the gain register to 0x4000 and clears the latched diagnostic flags
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check(gainControl, 16'h4000);
    repeat (3) @(negedge clk);
    u_phyd_host_model.rd(phyd_pkg::ADDR_DIAG, d);
    check(d, 16'h0300);
    wrap_up();
  end
endmodule : phy_autoneg_diagnostic_regs_test
